/* File: rtl/cdec_decoder.sv */
// SDRAM command decoder: samples the command pins, decodes commands,
// tracks power state and the data burst with its automatic bank close.
// Assumes the pad logic hands over the rising and falling CA halves each cycle.
`timescale 1ns/100ps
module cdec_decoder #(
	parameter int NUM_BANKS = 8,
	parameter logic [cdec_pkg::BURST_CNT_WIDTH-1:0] BURST_LEN = cdec_pkg::BURST_CYCLES
) (
	input wire logic clk_i, // 200 MHz clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic cs_n_i, // Chip select pin, active low
	input wire logic cke_i, // Clock enable pin
	input wire logic [cdec_pkg::CA_WIDTH-1:0] ca_rise_i, // CA bus, rising half
	input wire logic [cdec_pkg::CA_WIDTH-1:0] ca_fall_i, // CA bus, falling half
	output cdec_pkg::cdec_cmd_t cmd_o, // Decoded command fields
	output logic cmd_valid_o, // One-cycle pulse per command
	output cdec_pkg::cdec_pwr_t pwr_state_o, // Power state
	output logic burst_active_o, // Data burst running
	output logic auto_close_o, // Pulse: bank closes after burst
	output logic illegal_o // Sticky illegal event seen
);
	import cdec_pkg::*;

	cdec_pins_t pins_meta, pins_sync;
	logic cke_prev;
	cdec_cmd_t next_cmd;
	logic next_cmd_valid;
	cdec_pwr_t next_pwr;
	logic next_illegal;
	logic [BURST_CNT_WIDTH-1:0] burst_cnt, next_burst_cnt;
	logic close_pending, next_close_pending;
	logic next_burst_active, next_auto_close;
	logic is_idle;
	logic [3:0] op;

	// Two-stage sampling of the pins, rising edge only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins_meta <= PINS_RESET;
			pins_sync <= PINS_RESET;
			cke_prev <= 1'b1;
		end else begin
			pins_meta <= '{cs_n: cs_n_i, cke: cke_i, ca_rise: ca_rise_i, ca_fall: ca_fall_i};
			pins_sync <= pins_meta;
			cke_prev <= pins_sync.cke;
		end
	end

	assign op = pins_sync.ca_rise[3:0];
	assign is_idle = pins_sync.cs_n || (op[2:0] == 3'h7);

	always_comb begin
		next_cmd = cmd_o;
		next_cmd_valid = 1'b0;
		next_pwr = pwr_state_o;
		next_illegal = illegal_o;
		next_burst_cnt = burst_cnt;
		next_close_pending = close_pending;
		next_auto_close = 1'b0;
		// Burst runs down on its own; idle does not touch it
		if (burst_cnt != '0) begin
			next_burst_cnt = burst_cnt - 1'b1;
			if (burst_cnt == 4'h1 && close_pending) begin
				next_auto_close = 1'b1;
				next_close_pending = 1'b0;
			end
		end
		// Decode from CS, CA0..CA3 and both CKE samples
		case ({cke_prev, pins_sync.cke})
			2'b11: begin
				if (pwr_state_o != CDEC_PWR_ACTIVE) begin
					next_illegal = 1'b1;
				end else if (!is_idle) begin
					next_cmd = '0;
					next_cmd_valid = 1'b1;
					next_cmd.bank = pins_sync.ca_rise[BANK_POS +: BANK_WIDTH];
					if (op[1:0] == 2'b10) begin
						next_cmd.code = CDEC_CMD_ACTIVATE;
						next_cmd.row = {pins_sync.ca_rise[ROW_HI_POS +: 5], pins_sync.ca_fall[7:0]};
					end else begin
						case (op)
							4'h0, 4'h8: begin
								next_cmd.code = op[3] ? CDEC_CMD_MODE_READ : CDEC_CMD_MODE_WRITE;
								next_cmd.bank = '0;
								next_cmd.mode_reg_index = {pins_sync.ca_fall[MA_HI_POS +: 2],
									pins_sync.ca_rise[MA_LO_POS +: 6]};
								next_cmd.mode_reg_value = op[3] ? 8'h00 : pins_sync.ca_fall[OP_POS +: 8];
							end
							4'h4, 4'hC: begin
								next_cmd.code = op[3] ? CDEC_CMD_REF_ALL : CDEC_CMD_REF_ONE;
								next_cmd.bank = '0;
								if (!op[3] && NUM_BANKS != BANKS_FOR_PB_REFRESH) begin
									next_cmd_valid = 1'b0;
									next_illegal = 1'b1;
								end
							end
							4'h1, 4'h9, 4'h5, 4'hD: begin
								next_cmd.code = op[2] ? CDEC_CMD_READ : CDEC_CMD_WRITE;
								next_cmd.col = {pins_sync.ca_fall[COL_HI_POS +: 7],
									pins_sync.ca_rise[COL_LO_POS +: 2], 1'b0};
								next_cmd.auto_close_flag = pins_sync.ca_fall[AP_POS];
								next_burst_cnt = BURST_LEN;
								next_close_pending = pins_sync.ca_fall[AP_POS];
							end
							4'hB: begin
								next_cmd.code = CDEC_CMD_PRECHARGE;
								next_cmd.all_banks_flag = pins_sync.ca_rise[AB_POS];
								if (pins_sync.ca_rise[AB_POS]) begin
									next_cmd.bank = '0;
								end
							end
							4'h3: begin
								next_cmd.code = CDEC_CMD_BURST_STOP;
								next_cmd.bank = '0;
								next_burst_cnt = '0;
								next_close_pending = 1'b0;
							end
							default: begin
								next_cmd_valid = 1'b0;
								next_illegal = 1'b1;
							end
						endcase
					end
				end
			end
			2'b10: begin
				if (pwr_state_o != CDEC_PWR_ACTIVE) begin
					next_illegal = 1'b1;
				end else if (pins_sync.cs_n) begin
					next_pwr = CDEC_PWR_LOW;
				end else if (op[2:0] == 3'h4) begin
					next_pwr = CDEC_PWR_SELF_REFRESH;
				end else if (op[2:0] == 3'h3) begin
					next_pwr = CDEC_PWR_DEEP_SLEEP;
				end else begin
					next_illegal = 1'b1;
				end
			end
			2'b01: begin
				if (pins_sync.cs_n) begin
					next_pwr = CDEC_PWR_ACTIVE;
				end else begin
					next_illegal = 1'b1;
				end
			end
			default: begin
				next_pwr = pwr_state_o;
			end
		endcase
		next_burst_active = (next_burst_cnt != '0);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_o <= '0;
			cmd_valid_o <= 1'b0;
			pwr_state_o <= CDEC_PWR_ACTIVE;
			illegal_o <= 1'b0;
			burst_cnt <= '0;
			close_pending <= 1'b0;
			burst_active_o <= 1'b0;
			auto_close_o <= 1'b0;
		end else begin
			cmd_o <= next_cmd;
			cmd_valid_o <= next_cmd_valid;
			pwr_state_o <= next_pwr;
			illegal_o <= next_illegal;
			burst_cnt <= next_burst_cnt;
			close_pending <= next_close_pending;
			burst_active_o <= next_burst_active;
			auto_close_o <= next_auto_close;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_IDLE_NO_CMD: assert property (cke_prev && pins_sync.cke && is_idle |=> !cmd_valid_o)
		else $error("Idle command produced a command");
	AST_IDLE_ENCODING: assert property (cke_prev && pins_sync.cke && !pins_sync.cs_n
		&& op[2:0] == 3'h7 |=> !cmd_valid_o && $stable(illegal_o))
		else $error("CS low idle encoding not treated as idle");
	AST_IDLE_KEEPS_BURST: assert property (burst_cnt > 4'h1 && is_idle |=> burst_active_o)
		else $error("Idle aborted a burst");
	AST_ILLEGAL_STICKY: assert property (illegal_o |=> illegal_o)
		else $error("Illegal flag dropped without reset");
	AST_PRE_ALL_BANKS: assert property (cmd_valid_o && cmd_o.code == CDEC_CMD_PRECHARGE
		&& cmd_o.all_banks_flag |-> cmd_o.bank == '0)
		else $error("All-bank precharge carries a bank");
	AST_MRW_DECODE: assert property (pwr_state_o == CDEC_PWR_ACTIVE && cke_prev && pins_sync.cke
		&& !pins_sync.cs_n && op == 4'h0 |=> cmd_valid_o && cmd_o.code == CDEC_CMD_MODE_WRITE)
		else $error("Mode write not decoded");
	AST_SELF_REFRESH_STATE_ENTRY: assert property (pwr_state_o == CDEC_PWR_ACTIVE && cke_prev && !pins_sync.cke
		&& !pins_sync.cs_n && op[2:0] == 3'h4 |=> pwr_state_o == CDEC_PWR_SELF_REFRESH)
		else $error("Self refresh entry missed");
	AST_CMD_NEEDS_CS: assert property (cmd_valid_o
		|-> $past(!pins_sync.cs_n && pins_sync.cke && cke_prev))
		else $error("Command without chip select and steady clock enable");
	// A read or write loads the full burst count in the cycle it is reported
	AST_BURST_LENGTH: assert property (cmd_valid_o
		&& (cmd_o.code == CDEC_CMD_READ || cmd_o.code == CDEC_CMD_WRITE)
		|-> burst_active_o && burst_cnt == BURST_LEN)
		else $error("Burst not started by read or write");
	// A new burst may start in the closing cycle, so only the old burst is checked
	AST_AUTO_CLOSE: assert property (auto_close_o
		|-> $past(burst_active_o) && $past(close_pending))
		else $error("Auto close outside burst end");
	AST_ACT_ROW_HALVES: assert property (cmd_valid_o && cmd_o.code == CDEC_CMD_ACTIVATE
		|-> cmd_o.row[7:0] == $past(pins_sync.ca_fall[7:0]))
		else $error("Activate row low byte not from falling half");
	AST_PB_REFRESH: assert property (cmd_valid_o && cmd_o.code == CDEC_CMD_REF_ONE
		|-> NUM_BANKS == BANKS_FOR_PB_REFRESH)
		else $error("Per-bank refresh accepted on wrong bank count");
endmodule

/* File: rtl/cdec_pkg.sv */
// Package for the SDRAM command decoder: commands, power states, pin group
// Assumes one 200 MHz clock; the pad logic presents both CA halves per cycle
package cdec_pkg;
	localparam int CA_WIDTH = 10;
	localparam int BANK_WIDTH = 3;
	localparam int ROW_WIDTH = 13;
	localparam int COL_WIDTH = 10;
	localparam int MR_WIDTH = 8;
	localparam int BURST_CNT_WIDTH = 4;
	// Clock cycles of a burst of eight at two beats per clock
	localparam logic [BURST_CNT_WIDTH-1:0] BURST_CYCLES = 4'h4;
	localparam int BANKS_FOR_PB_REFRESH = 8;
	// Field positions on the rising half
	localparam int ROW_HI_POS = 2;
	localparam int BANK_POS = 7;
	localparam int COL_LO_POS = 5;
	localparam int MA_LO_POS = 4;
	localparam int AB_POS = 4;
	// Field positions on the falling half
	localparam int AP_POS = 0;
	localparam int COL_HI_POS = 1;
	localparam int MA_HI_POS = 0;
	localparam int OP_POS = 2;

	typedef enum logic [3:0] {
		CDEC_CMD_NONE = 4'h0,
		CDEC_CMD_MODE_WRITE = 4'h1,
		CDEC_CMD_MODE_READ = 4'h2,
		CDEC_CMD_REF_ONE = 4'h3,
		CDEC_CMD_REF_ALL = 4'h4,
		CDEC_CMD_ACTIVATE = 4'h5,
		CDEC_CMD_WRITE = 4'h6,
		CDEC_CMD_READ = 4'h7,
		CDEC_CMD_PRECHARGE = 4'h8,
		CDEC_CMD_BURST_STOP = 4'h9
	} cdec_cmd_code_t;

	typedef enum logic [1:0] {
		CDEC_PWR_ACTIVE = 2'h0,
		CDEC_PWR_LOW = 2'h1,
		CDEC_PWR_SELF_REFRESH = 2'h2,
		CDEC_PWR_DEEP_SLEEP = 2'h3
	} cdec_pwr_t;

	typedef struct packed {
		logic cs_n;
		logic cke;
		logic [CA_WIDTH-1:0] ca_rise;
		logic [CA_WIDTH-1:0] ca_fall;
	} cdec_pins_t;

	typedef struct packed {
		cdec_cmd_code_t code;
		logic [BANK_WIDTH-1:0] bank;
		logic [ROW_WIDTH-1:0] row;
		logic [COL_WIDTH-1:0] col;
		logic [MR_WIDTH-1:0] mode_reg_index;
		logic [MR_WIDTH-1:0] mode_reg_value;
		logic auto_close_flag;
		logic all_banks_flag;
	} cdec_cmd_t;

	localparam cdec_pins_t PINS_RESET = '{cs_n: 1'b1, cke: 1'b1, ca_rise: '1, ca_fall: '1};
endpackage

/* File: dv/cdec_ctrl_model.sv */
// Memory controller model that drives the decoder's command pins
// Assumes the bench hands over one request per cycle at the rising edge
`timescale 1ns/100ps
module cdec_ctrl_model (
	input wire logic clk_i, // 200 MHz clock
	input wire cdec_pkg::cdec_pins_t req_i, // Pin levels for the next cycle
	output logic cs_n_o, // Chip select, active low
	output logic cke_o, // Clock enable
	output logic [cdec_pkg::CA_WIDTH-1:0] ca_rise_o, // CA rising half
	output logic [cdec_pkg::CA_WIDTH-1:0] ca_fall_o // CA falling half
);
	import cdec_pkg::*;
	logic flip = 1'b0;
	always @(posedge clk_i) begin
		flip <= ~flip;
		cs_n_o <= req_i.cs_n;
		cke_o <= req_i.cke;
		if (req_i.cs_n) begin
			// Deselected: CA carries no meaning, so it toggles
			ca_rise_o <= {CA_WIDTH{flip}};
			ca_fall_o <= ~{CA_WIDTH{flip}};
		end else begin
			ca_rise_o <= req_i.ca_rise;
			ca_fall_o <= req_i.ca_fall;
		end
	end
endmodule

/* File: dv/test_sdram_command_decoder.sv */
// Self-checking bench of the command decoder with a controller model
// Assumes the model adds one register stage in front of the pins
`timescale 1ns/100ps
module test_sdram_command_decoder;
	import cdec_pkg::*;
	logic clk_i;
	logic rst_i;
	logic got;
	cdec_pins_t req;
	logic cs_n, cke, burst, auto_close, illegal, valid, illegal4;
	logic [CA_WIDTH-1:0] ca_r, ca_f;
	cdec_cmd_t cmd;
	cdec_pwr_t pwr;
	int mismatches = 0, n_compared = 0, cycles = 0, n;
	logic [9:0] ops [10] = '{10'h000, 10'h008, 10'h004, 10'h00C, 10'h2CE, 10'h001, 10'h003, 10'h30B, 10'h31B, 10'h005};
	cdec_cmd_code_t codes [10] = '{CDEC_CMD_MODE_WRITE, CDEC_CMD_MODE_READ, CDEC_CMD_REF_ONE, CDEC_CMD_REF_ALL,
		CDEC_CMD_ACTIVATE, CDEC_CMD_WRITE, CDEC_CMD_BURST_STOP, CDEC_CMD_PRECHARGE, CDEC_CMD_PRECHARGE, CDEC_CMD_READ};
	logic [9:0] pw_ca [3] = '{10'h004, 10'h003, 10'h3FF};
	cdec_pwr_t pw_exp [3] = '{CDEC_PWR_SELF_REFRESH, CDEC_PWR_DEEP_SLEEP, CDEC_PWR_LOW};
	cdec_ctrl_model model (.clk_i(clk_i), .req_i(req), .cs_n_o(cs_n), .cke_o(cke), .ca_rise_o(ca_r), .ca_fall_o(ca_f));
	cdec_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .cke_i(cke), .ca_rise_i(ca_r), .ca_fall_i(ca_f),
		.cmd_o(cmd), .cmd_valid_o(valid), .pwr_state_o(pwr), .burst_active_o(burst), .auto_close_o(auto_close),
		.illegal_o(illegal));
	cdec_decoder #(.NUM_BANKS(4)) dut_4bank (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .cke_i(cke),
		.ca_rise_i(ca_r), .ca_fall_i(ca_f), .cmd_o(), .cmd_valid_o(), .pwr_state_o(), .burst_active_o(),
		.auto_close_o(), .illegal_o(illegal4));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic send(input logic c_n, input logic ck, input logic [9:0] r, input logic [9:0] f);
		req <= '{cs_n: c_n, cke: ck, ca_rise: r, ca_fall: f};
		@(posedge clk_i);
		req <= '{cs_n: 1'b1, cke: ck, ca_rise: '1, ca_fall: '1};
	endtask
	// Waits a bounded time for a decoded command, returns at a rising edge
	task automatic wait_cmd(output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 8 && !seen; i++) begin
			@(negedge clk_i);
			seen = (valid === 1'b1);
		end
		@(posedge clk_i);
	endtask
	initial begin
		req = '{cs_n: 1'b1, cke: 1'b1, ca_rise: '1, ca_fall: '1};
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		check("rst valid", valid, 1'b0);
		check("rst pwr", pwr, CDEC_PWR_ACTIVE);
		rst_i <= 1'b0;
		@(posedge clk_i);
		send(1'b1, 1'b1, 10'h000, 10'h000);
		wait_cmd(got);
		check("idle deselect", got, 1'b0);
		send(1'b0, 1'b1, 10'h3F7, 10'h000);
		wait_cmd(got);
		check("idle selected", got, 1'b0);
		$display("test idle done");
		for (int i = 0; i < 10; i++) begin
			send(1'b0, 1'b1, ops[i], 10'h0A5);
			wait_cmd(got);
			check("valid", got, 1'b1);
			check("code", cmd.code, codes[i]);
			if (i <= 1) begin
				check("mode index", cmd.mode_reg_index, 8'h40);
				check("mode value", cmd.mode_reg_value, i == 0 ? 8'h29 : 8'h00);
			end
			if (i == 4) begin
				check("row", cmd.row, 13'h13A5);
				check("bank", cmd.bank, 3'h5);
			end
			if (i == 5 || i == 9) begin
				check("col", cmd.col, 10'h290);
				check("close flag", cmd.auto_close_flag, 1'b1);
			end
			if (i >= 7 && i <= 8) begin
				check("pre bank", cmd.bank, i == 7 ? 3'h6 : 3'h0);
				check("all flag", cmd.all_banks_flag, i == 8);
			end
		end
		// Idles during the burst must not cut it short
		req <= '{cs_n: 1'b0, cke: 1'b1, ca_rise: 10'h3F7, ca_fall: 10'h000};
		n = 1;
		repeat (10) begin
			@(negedge clk_i);
			if (burst !== 1'b1) break;
			n++;
		end
		check("burst len", n, BURST_CYCLES);
		check("auto close", auto_close, 1'b1);
		@(posedge clk_i);
		check("8 bank ref", illegal, 1'b0);
		check("4 bank ref", illegal4, 1'b1);
		$display("test commands done");
		for (int i = 0; i < 3; i++) begin
			send(i == 2, 1'b0, pw_ca[i], 10'h000);
			repeat (6) @(posedge clk_i);
			check("pwr entry", pwr, pw_exp[i]);
			send(1'b1, 1'b1, 10'h3FF, 10'h3FF);
			repeat (6) @(posedge clk_i);
			check("pwr exit", pwr, CDEC_PWR_ACTIVE);
		end
		send(1'b0, 1'b0, 10'h005, 10'h000);
		wait_cmd(got);
		check("bad entry cmd", got, 1'b0);
		check("illegal", illegal, 1'b1);
		$display("test power done");
		give_verdict();
	end
endmodule
